// >>> pkg/pm_regs_defines.vh
`ifndef PM_REGS_DEFINES_VH
`define PM_REGS_DEFINES_VH

// Register byte addresses on the APB
`define PM_CAP_ADDR 8'hA0
`define PM_CSR_ADDR 8'hA4
`define PM_IRQ_STATUS_ADDR 8'hB0
`define PM_IRQ_MASK_ADDR 8'hB4
`define PM_CTRL_ADDR 8'hB8

// Capabilities word fields
// Wake-capable states, bits 15 to 11: none from D3cold, all others allowed
`define PM_CAP_WAKE_STATES 5'h0F
`define PM_CAP_D2_SUP 1'h1
`define PM_CAP_FIRST_LOW_STATE_SUPPORTED 1'h1
`define PM_CAP_RSVD 3'h0
`define PM_CAP_DSI 1'h1
`define PM_CAP_VERSION 3'h1

// Control/status word field positions
`define PM_CSR_WAKE_PEND_BIT 15
`define PM_CSR_WAKE_EN_BIT 8
`define PM_CSR_RESET 16'h0000

// Power state encodings
`define PM_STATE_D0 2'h0
`define PM_STATE_D1 2'h1
`define PM_STATE_D2 2'h2
`define PM_STATE_D3HOT 2'h3

// Interrupt status bits
`define PM_IRQ_WAKE_BIT 0
`define PM_IRQ_STATE_BIT 1
`define PM_IRQ_D3_EXIT_BIT 2

`endif

// >>> rtl/pm_sync3.v
`timescale 1ns/10ps
`default_nettype none

// Three-stage pin synchroniser; a change counts once stages two and three agree
module pm_sync3 (
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    // Pin and qualified level
    input wire pinIn,
    output reg levelOut
);

    reg stage1Q;
    reg stage2Q;
    reg stage3Q;

    // First stage feeds only the second
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stage1Q <= 1'b0;
            stage2Q <= 1'b0;
            stage3Q <= 1'b0;
            levelOut <= 1'b0;
        end else begin
            stage1Q <= pinIn;
            stage2Q <= stage1Q;
            stage3Q <= stage2Q;
            if (stage2Q == stage3Q) begin
                levelOut <= stage3Q;
            end
        end
    end

endmodule // pm_sync3

`default_nettype wire

// >>> rtl/pm_state_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "pm_regs_defines.vh"

// Tracks power state moves and pulses the group reset on a D3hot to D0 exit
module pm_state_ctrl (
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    // New state request
    input wire stateWrite,
    input wire [1:0] stateNew,
    // Status
    output reg [1:0] stateQ,
    output reg stateChange,
    output reg d3Exit
);

    // A single cycle reset pulse is enough for the synchronous register groups
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stateQ <= `PM_STATE_D0;
            stateChange <= 1'b0;
            d3Exit <= 1'b0;
        end else begin
            stateChange <= stateWrite && (stateNew != stateQ);
            d3Exit <= stateWrite && (stateQ == `PM_STATE_D3HOT) &&
                (stateNew == `PM_STATE_D0);
            if (stateWrite) begin
                stateQ <= stateNew;
            end
        end
    end

endmodule // pm_state_ctrl

`default_nettype wire

// >>> rtl/pm_regs.v
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "pm_regs_defines.vh"

// Function
// - Capabilities bit 9 reads one: first low-power state supported.
// - Capabilities bits 8 to 6 read zero.
// - Capabilities bit 5 reads one: special initialisation needed.
// - Capabilities bit 4 read-only auxiliary-supply flag, meaningful only with bit 15.
// - Capabilities bit 3 read-only flag: wake needs bus clock.
// - Capabilities bits 2 to 0 read version 001b.
// - Group reset on D3hot to D0 leaves control/status word unchanged.
// - D3hot to D0 resets other register groups, keeps this one.
// - Wake event sets wake-pending bit 15 regardless of wake enable.
// - Writing one clears wake-pending and releases wake output; zero ignored.
// - Data scale bits 14 to 13 read zero.
// - Data selector bits 12 to 9 read zero.
// - Wake enable bit 8 gates wake output assertion.
// - Control/status bits 7 to 2 read zero.
// - Two-bit power state field reports and sets state, 00 D0 to 11 D3hot.
// - Capabilities bit 15 zero, bits 14 to 11 one: wake from D3hot, D2, D1, D0.
module pm_regs #(
    parameter AUX_NEEDED = 1'b0,
    parameter CLOCK_FOR_WAKE = 1'b0
) (
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Wake event pin from the function logic
    input wire wakeEventPin,
    // Power management outputs
    output reg wakeOutN,
    output reg [1:0] powerState,
    output reg groupResetN,
    output reg irq
);

    reg wakePendingQ;
    reg wakeEnableQ;
    reg [2:0] irqStatusQ;
    reg [2:0] irqMaskQ;
    reg groupResetHoldQ;
    reg wakeLevelQ;
    wire wakeLevel;
    wire [1:0] stateQ;
    wire stateChange;
    wire d3Exit;
    wire wakeRise;
    wire [15:0] capWord;
    wire [15:0] csrWord;
    wire setupPhase;
    wire wrAccess;
    reg [31:0] readMux;
    reg addrValid;

    // Address check used by both write decode and error response
    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr == `PM_CAP_ADDR) || (addr == `PM_CSR_ADDR) ||
                (addr == `PM_IRQ_STATUS_ADDR) || (addr == `PM_IRQ_MASK_ADDR) ||
                (addr == `PM_CTRL_ADDR);
        end
    endfunction

    // Wake event pin crosses in through three flops
    pm_sync3 u_wake_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pinIn(wakeEventPin),
        .levelOut(wakeLevel)
    );

    assign wakeRise = wakeLevel && !wakeLevelQ;

    // Writes commit in the access phase, the only cycle the slave answers
    assign setupPhase = psel && !penable;
    assign wrAccess = psel && penable && pwrite && mapped(paddr);

    pm_state_ctrl u_state (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .stateWrite(wrAccess && (paddr == `PM_CSR_ADDR)),
        .stateNew(pwdata[1:0]),
        .stateQ(stateQ),
        .stateChange(stateChange),
        .d3Exit(d3Exit)
    );

    // Capabilities word is all constants
    assign capWord = {`PM_CAP_WAKE_STATES,
        `PM_CAP_D2_SUP,
        `PM_CAP_FIRST_LOW_STATE_SUPPORTED,
        `PM_CAP_RSVD,
        `PM_CAP_DSI,
        AUX_NEEDED[0],
        CLOCK_FOR_WAKE[0],
        `PM_CAP_VERSION};

    // Control/status word; data and reserved fields fixed at zero
    assign csrWord = {wakePendingQ,
        2'h0,
        4'h0,
        wakeEnableQ,
        6'h00,
        stateQ};

    // Read mux
    always @* begin
        addrValid = mapped(paddr);
        case (paddr)
            `PM_CAP_ADDR: readMux = {16'h0000, capWord};
            `PM_CSR_ADDR: readMux = {16'h0000, csrWord};
            `PM_IRQ_STATUS_ADDR: readMux = {29'h00000000, irqStatusQ};
            `PM_IRQ_MASK_ADDR: readMux = {29'h00000000, irqMaskQ};
            `PM_CTRL_ADDR: readMux = {31'h00000000, groupResetHoldQ};
            default: readMux = 32'h00000000;
        endcase
    end

    // APB answer: ready one cycle after setup, zero wait states
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase && !addrValid;
            prdata <= (setupPhase && !pwrite) ? readMux : 32'h00000000;
        end
    end

    // Control/status bits; only power-on reset touches them, never d3Exit
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wakePendingQ <= 1'b0;
            wakeEnableQ <= 1'b0;
            wakeLevelQ <= 1'b0;
        end else begin
            wakeLevelQ <= wakeLevel;
            if (wrAccess && (paddr == `PM_CSR_ADDR)) begin
                wakeEnableQ <= pwdata[`PM_CSR_WAKE_EN_BIT];
            end
            // Set wins over a same-cycle clear so no event is lost
            if (wakeRise) begin
                wakePendingQ <= 1'b1;
            end else if (wrAccess && (paddr == `PM_CSR_ADDR) &&
                    pwdata[`PM_CSR_WAKE_PEND_BIT]) begin
                wakePendingQ <= 1'b0;
            end
        end
    end

    // Group reset for other register blocks; this bank ignores it
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            groupResetN <= 1'b1;
            groupResetHoldQ <= 1'b0;
        end else begin
            groupResetN <= !d3Exit;
            if (d3Exit) begin
                groupResetHoldQ <= 1'b1;
            end else if (wrAccess && (paddr == `PM_CTRL_ADDR) && pwdata[0]) begin
                groupResetHoldQ <= 1'b0;
            end
        end
    end

    // Wake output, active low, tied to pending and enable
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wakeOutN <= 1'b1;
            powerState <= `PM_STATE_D0;
        end else begin
            wakeOutN <= !(wakePendingQ && wakeEnableQ);
            powerState <= stateQ;
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irqStatusQ <= 3'h0;
            irqMaskQ <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (wrAccess && (paddr == `PM_IRQ_MASK_ADDR)) begin
                irqMaskQ <= pwdata[2:0];
            end
            irqStatusQ <= (irqStatusQ &
                ~((wrAccess && (paddr == `PM_IRQ_STATUS_ADDR)) ? pwdata[2:0] : 3'h0)) |
                {d3Exit, stateChange, wakeRise};
            irq <= |(irqStatusQ & irqMaskQ);
        end
    end

endmodule // pm_regs

`default_nettype wire

// >>> verification/pm_regs_checker.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level watcher for the power register block
module pm_regs_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Power outputs
    input wire logic wakeOutN,
    input wire logic [1:0] powerState,
    input wire logic groupResetN
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [1:0] stateW_q;
    // Completed transfers only: the access cycle in which the slave answers
    wire csrWr = psel && penable && pready && pwrite && paddr == 8'hA4;
    wire csrRd = psel && penable && pready && !pwrite && paddr == 8'hA4;
    wire capRd = psel && penable && pready && !pwrite && paddr == 8'hA0;
    // Last state written, so the field can be followed after the sync delay
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) stateW_q <= 2'h0;
        else if (csrWr) stateW_q <= pwdata[1:0];
    end
    a_setup_ready: assert property (psel && !penable |=> pready) else $error("no ready");
    a_unmapped_error: assert property (pready |->
        pslverr == !(paddr inside {8'hA0, 8'hA4, 8'hB0, 8'hB4, 8'hB8})) else $error("bad slverr");
    a_caps_value: assert property (capRd |-> prdata == 32'h0000_7E21)
        else $error("caps word");
    a_caps_flags: assert property (capRd |-> prdata[4:0] == 5'h01)
        else $error("caps flags");
    a_csr_data_zero: assert property (csrRd |-> prdata[14:9] == 6'h00)
        else $error("csr data bits");
    a_csr_rsvd_zero: assert property (csrRd |-> prdata[7:2] == 6'h00)
        else $error("csr reserved bits");
    a_wake_gate: assert property (csrRd |-> wakeOutN != (prdata[15] & prdata[8]))
        else $error("wake gate");
    a_wake_clear: assert property (csrWr && pwdata[15] |-> ##[1:3] wakeOutN)
        else $error("wake kept");
    a_state_follows: assert property (csrWr |-> ##[1:4] powerState == stateW_q)
        else $error("state field");
    a_group_pulse: assert property (!groupResetN |=> groupResetN)
        else $error("long pulse");
endmodule // pm_regs_checker
bind pm_regs pm_regs_checker u_pm_regs_checker (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wakeOutN(wakeOutN), .powerState(powerState),
    .groupResetN(groupResetN));
`default_nettype wire

// >>> verification/pm_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module pm_regs_test;
    logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, wakeEventPin = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, wakeOutN, groupResetN, irq, err;
    logic [1:0] powerState;
    int errors = 0, checks = 0, grCnt = 0;
    pm_regs u_pm_regs (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wakeEventPin(wakeEventPin), .wakeOutN(wakeOutN),
        .powerState(powerState), .groupResetN(groupResetN), .irq(irq));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // Counts cycles of the group reset pulse
    always @(posedge sys_clk) begin
        if (rstn && groupResetN === 1'b0) grCnt++;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic ticks(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // One APB transfer; the slave's latency is not assumed, only bounded
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            test_done();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic chkRd(input string nm, input logic [7:0] a, input logic [31:0] ex);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, ex, rd)
    endtask
    initial begin
        ticks(5);
        rstn <= 1'b1;
        chkRd("caps", 8'hA0, 32'h0000_7E21);
        chkRd("csr", 8'hA4, 32'h0);
        xfer(1'b1, 8'hA0, 32'hFFFF_FFFF);
        chkRd("caps ro", 8'hA0, 32'h0000_7E21);
        chkRd("unmapped", 8'hC0, 32'h0);
        `CHK("slverr", 1'b1, err)
        xfer(1'b1, 8'hC0, 32'hFFFF_FFFF);
        `CHK("wr slverr", 1'b1, err)
        $display("test caps done");
        // Ones go to every read-only bit while stepping through the states
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, 8'hA4, 32'hFFFF_7FFC | s);
            ticks(4);
            `CHK("state", s[1:0], powerState)
            chkRd("csr rd", 8'hA4, 32'h0100 | s);
        end
        xfer(1'b1, 8'hA4, 32'h0100);
        ticks(6);
        `CHK("grst", 1, grCnt)
        chkRd("csr kept", 8'hA4, 32'h0100);
        chkRd("grst flag", 8'hB8, 32'h1);
        xfer(1'b1, 8'hB8, 32'h1);
        chkRd("grst clr", 8'hB8, 32'h0);
        $display("test states done");
        // Event with enable off, then enable, then clear
        xfer(1'b1, 8'hA4, 32'h0);
        wakeEventPin <= 1'b1;
        ticks(8);
        chkRd("pend", 8'hA4, 32'h8000);
        `CHK("wake off", 1'b1, wakeOutN)
        xfer(1'b1, 8'hA4, 32'h0100);
        ticks(3);
        `CHK("wake on", 1'b0, wakeOutN)
        chkRd("pend kept", 8'hA4, 32'h8100);
        xfer(1'b1, 8'hA4, 32'h8100);
        ticks(3);
        `CHK("wake rel", 1'b1, wakeOutN)
        chkRd("pend clr", 8'hA4, 32'h0100);
        $display("test wake done");
        // Interrupt status, mask and clear
        chkRd("irq st", 8'hB0, 32'h7);
        `CHK("irq masked", 1'b0, irq)
        xfer(1'b1, 8'hB4, 32'h1);
        ticks(2);
        `CHK("irq on", 1'b1, irq)
        xfer(1'b1, 8'hB0, 32'h7);
        ticks(2);
        `CHK("irq off", 1'b0, irq)
        chkRd("irq clr", 8'hB0, 32'h0);
        chkRd("mask", 8'hB4, 32'h1);
        $display("test irq done");
        test_done();
    end
endmodule // pm_regs_test
`default_nettype wire
